// ===== pkg/mbw_defines.svh
/*
 Offsets, field values, limits and area bounds for the write and loop-test message handler.
 Assumes it is included by bare name from the design file and the bench.
*/
`ifndef MBW_DEFINES_SVH
`define MBW_DEFINES_SVH

// Function codes and subfunction
`define MBW_FN_WRITE1 8'h06
`define MBW_FN_DIAG 8'h08
`define MBW_FN_WRITEN 8'h10
`define MBW_SUB_ECHO 16'h0000
`define MBW_EXC_FLAG 8'h80
`define MBW_EXC_FUNC 8'h01
`define MBW_EXC_ADDR 8'h02
`define MBW_EXC_DATA 8'h03
`define MBW_BCAST_ADDR 8'h00
// Frame geometry
`define MBW_FIXED_LEN 9'h008
`define MBW_MULTI_HDR 9'h009
`define MBW_EXC_LEN 9'h005
`define MBW_ACK_BODY 9'h006
`define MBW_MIN_LEN 9'h004
`define MBW_DATA_OFS 9'h007
`define MBW_BUF_BYTES 9'h103
`define MBW_MAX_REGS 16'h007d
`define MBW_BC_MIN 8'h02
`define MBW_BC_MAX 8'hfa
// Residue seed and polynomial of the frame check
`define MBW_CRC_INIT 16'hffff
`define MBW_CRC_POLY 16'ha001
// Writable areas, field values (register number minus 40001)
`define MBW_ENV_LO 16'h0000
`define MBW_ENV_HI 16'h00ff
`define MBW_PAR_LO 16'h03e8
`define MBW_PAR_HI 16'h0fff
`endif

// ===== pkg/mbw_pkg.sv
/*
 Types shared by the message handler and its bench: states, reply kinds, write request.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package mbw_pkg;
	typedef enum logic [1:0] {
		MBW_IDLE = 2'h0,
		MBW_CHECK = 2'h1,
		MBW_WRITE = 2'h3,
		MBW_SEND = 2'h2
	} mbw_state_t;

	typedef enum logic [1:0] {
		MBW_RESP_ECHO = 2'h0,
		MBW_RESP_ACK = 2'h1,
		MBW_RESP_EXC = 2'h2
	} mbw_resp_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} mbw_wr_t;
endpackage

// ===== hw/mbw_slave.sv
/*
 Slave message handler: takes received frame bytes, checks them, writes holding registers
 and streams the reply bytes out.
 Assumes a byte receiver and transmitter on clk_sys that mark frame ends and line errors,
 and a holding register store that takes one write per wrValid/wrReady handshake.
*/
// How it works
// - Single write: address, function, register address, value, each high byte first.
// - Address field is holding register number minus 40001.
// - Single write value is two bytes and goes into the addressed register.
// - Single writes allowed only in environment and parameter areas.
// - Address 0 on single or multiple write is broadcast and still writes.
// - Broadcast writes never get a reply.
// - Good single write is answered by an exact copy of the query.
// - Diagnostic subfunction 0000 sends the query back unchanged.
// - Diagnostic reply repeats every query byte as a link check.
// - Diagnostic data is any two-byte value, echoed unchecked.
// - Multiple write: start, count, byte count, data words, check.
// - At most 125 registers per multiple write.
// - Byte count lies in 02..FA and equals twice the register count.
// - Good multiple write answers address, function, start, count and check.
// - Parity, check, overrun, framing or busy error: frame dropped, no reply.
// - Illegal function, address or data: function plus 80 and code 01/02/03.
`timescale 1ns/100ps
`include "mbw_defines.svh"

module mbw_slave (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [7:0] slaveAddr,
	input wire logic [7:0] rxByte,
	input wire logic rxValid,
	input wire logic rxErr,
	input wire logic rxEnd,
	input wire logic busy,
	output logic [7:0] txByte,
	output logic txValid,
	input wire logic txReady,
	output mbw_pkg::mbw_wr_t wrReq,
	output logic wrValid,
	input wire logic wrReady,
	output logic evDone,
	output logic evDrop
);
	// One step of the reflected frame check
	function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] x;
		x = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			x = x[0] ? ((x >> 1) ^ `MBW_CRC_POLY) : (x >> 1);
		return x;
	endfunction
	// Area of a register field: 0 none, 1 environment, 2 parameters
	function automatic logic [1:0] areaOf(input logic [15:0] a);
		if (a >= `MBW_ENV_LO && a <= `MBW_ENV_HI)
			return 2'h1;
		else if (a >= `MBW_PAR_LO && a <= `MBW_PAR_HI)
			return 2'h2;
		else
			return 2'h0;
	endfunction

	mbw_pkg::mbw_state_t state_r;
	mbw_pkg::mbw_resp_t respKind_r;
	logic [7:0] rxBuf_r [0:`MBW_BUF_BYTES-1];
	logic [8:0] rxCnt_r;
	logic [15:0] rxCrc_r;
	logic rxBad_r;
	logic [7:0] excCode_r;
	logic bcast_r;
	logic [6:0] nWords_r;
	logic [6:0] wrIdx_r;
	logic [8:0] txIdx_r;
	logic [8:0] respLen_r;
	logic [15:0] txCrc_r;
	logic [7:0] txByte_r;
	logic txValid_r;
	mbw_pkg::mbw_wr_t wrReq_r;
	logic wrValid_r;
	logic evDone_r;
	logic evDrop_r;

	// Field views of the held frame, all fields high byte first
	wire logic [7:0] fAddr = rxBuf_r[0];
	wire logic [7:0] fFunc = rxBuf_r[1];
	wire logic [15:0] fWord1 = {rxBuf_r[2], rxBuf_r[3]};
	wire logic [15:0] fWord2 = {rxBuf_r[4], rxBuf_r[5]};
	wire logic [7:0] fByteCnt = rxBuf_r[6];
	wire logic isW1 = fFunc == `MBW_FN_WRITE1;
	wire logic isDiag = fFunc == `MBW_FN_DIAG;
	wire logic isWn = fFunc == `MBW_FN_WRITEN;

	// Frame-level acceptance; residue is zero when the trailing check word matches
	wire logic isBcast = fAddr == `MBW_BCAST_ADDR;
	wire logic forMe = (fAddr == slaveAddr) && !isBcast;
	wire logic frameGood = !rxBad_r && !busy && rxCrc_r == 16'h0000
		&& rxCnt_r >= `MBW_MIN_LEN;
	// Broadcast only counts for the two write functions
	wire logic addressed = forMe || (isBcast && (isW1 || isWn));

	// Multiple write geometry checks
	wire logic [8:0] wnLen = 9'(fByteCnt) + `MBW_MULTI_HDR;
	wire logic cntOk = fWord2 != 16'h0000 && fWord2 <= `MBW_MAX_REGS;
	wire logic bcOk = fByteCnt >= `MBW_BC_MIN && fByteCnt <= `MBW_BC_MAX
		&& {8'h00, fByteCnt} == {fWord2[14:0], 1'b0};
	wire logic [15:0] wnLast = 16'(fWord1 + fWord2 - 16'h0001);
	wire logic wnAreaOk = areaOf(fWord1) != 2'h0 && areaOf(fWord1) == areaOf(wnLast);
	wire logic [15:0] wnDataCnt = 16'(wnLen);

	// Exception decision, zero when the query is legal
	logic [7:0] excNow;
	always_comb
	begin
		excNow = 8'h00;
		if (isW1)
		begin
			if (rxCnt_r != `MBW_FIXED_LEN)
				excNow = `MBW_EXC_DATA; // value is fixed at two bytes
			else if (areaOf(fWord1) == 2'h0)
				excNow = `MBW_EXC_ADDR;
		end
		else if (isDiag)
		begin
			if (rxCnt_r != `MBW_FIXED_LEN)
				excNow = `MBW_EXC_DATA;
			else if (fWord1 != `MBW_SUB_ECHO)
				excNow = `MBW_EXC_FUNC; // data word itself never checked
		end
		else if (isWn)
		begin
			if (!cntOk || !bcOk || rxCnt_r != wnDataCnt[8:0])
				excNow = `MBW_EXC_DATA;
			else if (!wnAreaOk)
				excNow = `MBW_EXC_ADDR;
		end
		else
			excNow = `MBW_EXC_FUNC;
	end

	// Silent cases: bad frame, not ours, or broadcast that would need a reply
	wire logic dropNow = !frameGood || !addressed || (isBcast && excNow != 8'h00);

	// Next word to write: field value is register number minus 40001
	wire logic [8:0] wordPos = `MBW_DATA_OFS + {1'b0, wrIdx_r, 1'b0};
	wire logic [15:0] wordData = isW1 ? fWord2
		: {rxBuf_r[wordPos], rxBuf_r[9'(wordPos + 9'h001)]};
	wire logic [15:0] wordAddr = 16'(fWord1 + {9'h000, wrIdx_r});
	wire logic wrStep = !wrValid_r || wrReady;
	wire logic wrMore = wrIdx_r < nWords_r;

	// Reply byte at the current send position
	wire logic [7:0] crcByte = (txIdx_r == 9'(respLen_r - 9'h002)) ? txCrc_r[7:0]
		: txCrc_r[15:8]; // low byte first
	// The check word must not fold its own low byte into the high byte it sends next
	wire logic txBody = txIdx_r < 9'(respLen_r - 9'h002);
	logic [7:0] respByte;
	always_comb
	begin
		case (respKind_r)
			mbw_pkg::MBW_RESP_ECHO: respByte = rxBuf_r[txIdx_r];
			mbw_pkg::MBW_RESP_ACK: respByte = (txIdx_r < `MBW_ACK_BODY) ? rxBuf_r[txIdx_r]
				: crcByte;
			mbw_pkg::MBW_RESP_EXC:
			begin
				if (txIdx_r == 9'h000)
					respByte = fAddr;
				else if (txIdx_r == 9'h001)
					respByte = fFunc | `MBW_EXC_FLAG;
				else if (txIdx_r == 9'h002)
					respByte = excCode_r;
				else
					respByte = crcByte;
			end
			default: respByte = 8'h00;
		endcase
	end
	wire logic txStep = !txValid_r || txReady;
	wire logic txMore = txIdx_r < respLen_r;

	// Frame store; holds its last frame, so it needs no reset
	always_ff @(posedge clk_sys)
	begin
		if (state_r == mbw_pkg::MBW_IDLE && rxValid && rxCnt_r < `MBW_BUF_BYTES)
			rxBuf_r[rxCnt_r] <= rxByte;
	end

	// Receive count, running check and error mark; bytes outside idle are lost
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rxCnt_r <= 9'h000;
			rxCrc_r <= `MBW_CRC_INIT;
			rxBad_r <= 1'b0;
		end
		else if (state_r == mbw_pkg::MBW_CHECK)
		begin
			rxCnt_r <= 9'h000;
			rxCrc_r <= `MBW_CRC_INIT;
			rxBad_r <= 1'b0;
		end
		else if (state_r == mbw_pkg::MBW_IDLE && rxValid)
		begin
			rxCrc_r <= crcStep(rxCrc_r, rxByte);
			rxCnt_r <= (rxCnt_r < `MBW_BUF_BYTES) ? 9'(rxCnt_r + 9'h001) : rxCnt_r;
			rxBad_r <= rxBad_r || rxErr || rxCnt_r == `MBW_BUF_BYTES; // overrun too
		end
	end

	// Sequencer: decide, write, then send or fall silent
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= mbw_pkg::MBW_IDLE;
			respKind_r <= mbw_pkg::MBW_RESP_ECHO;
			excCode_r <= 8'h00;
			bcast_r <= 1'b0;
			nWords_r <= 7'h00;
			respLen_r <= 9'h000;
			evDone_r <= 1'b0;
			evDrop_r <= 1'b0;
		end
		else
		begin
			evDone_r <= 1'b0;
			evDrop_r <= 1'b0;
			case (state_r)
				mbw_pkg::MBW_IDLE:
					if (rxEnd)
						state_r <= mbw_pkg::MBW_CHECK;
				mbw_pkg::MBW_CHECK:
				begin
					excCode_r <= excNow;
					bcast_r <= isBcast;
					nWords_r <= isW1 ? 7'h01 : fWord2[6:0];
					if (dropNow)
					begin
						evDrop_r <= 1'b1;
						state_r <= mbw_pkg::MBW_IDLE;
					end
					else if (excNow != 8'h00)
					begin
						respKind_r <= mbw_pkg::MBW_RESP_EXC;
						respLen_r <= `MBW_EXC_LEN;
						state_r <= mbw_pkg::MBW_SEND;
					end
					else if (isDiag)
					begin
						respKind_r <= mbw_pkg::MBW_RESP_ECHO;
						respLen_r <= `MBW_FIXED_LEN;
						state_r <= mbw_pkg::MBW_SEND;
					end
					else
					begin
						respKind_r <= isW1 ? mbw_pkg::MBW_RESP_ECHO : mbw_pkg::MBW_RESP_ACK;
						respLen_r <= `MBW_FIXED_LEN;
						state_r <= mbw_pkg::MBW_WRITE; // broadcast writes too
					end
				end
				mbw_pkg::MBW_WRITE:
					if (wrStep && !wrMore)
					begin
						evDone_r <= bcast_r;
						state_r <= bcast_r ? mbw_pkg::MBW_IDLE : mbw_pkg::MBW_SEND;
					end
				mbw_pkg::MBW_SEND:
					if (txStep && !txMore)
					begin
						evDone_r <= 1'b1;
						state_r <= mbw_pkg::MBW_IDLE;
					end
				default: state_r <= mbw_pkg::MBW_IDLE;
			endcase
		end
	end

	// Register write handshake, words back to back while the store keeps up
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wrIdx_r <= 7'h00;
			wrValid_r <= 1'b0;
			wrReq_r <= '0;
		end
		else if (state_r != mbw_pkg::MBW_WRITE)
		begin
			wrIdx_r <= 7'h00;
			wrValid_r <= 1'b0;
		end
		else if (wrStep)
		begin
			wrValid_r <= wrMore;
			if (wrMore)
			begin
				wrReq_r <= '{addr: wordAddr, data: wordData};
				wrIdx_r <= 7'(wrIdx_r + 7'h01);
			end
		end
	end

	// Reply stream; check word built from the bytes as they leave
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			txIdx_r <= 9'h000;
			txValid_r <= 1'b0;
			txByte_r <= 8'h00;
			txCrc_r <= `MBW_CRC_INIT;
		end
		else if (state_r != mbw_pkg::MBW_SEND)
		begin
			txIdx_r <= 9'h000;
			txValid_r <= 1'b0;
			txCrc_r <= `MBW_CRC_INIT;
		end
		else if (txStep)
		begin
			txValid_r <= txMore;
			if (txMore)
			begin
				txByte_r <= respByte;
				txCrc_r <= txBody ? crcStep(txCrc_r, respByte) : txCrc_r;
				txIdx_r <= 9'(txIdx_r + 9'h001);
			end
		end
	end

	assign txByte = txByte_r;
	assign txValid = txValid_r;
	assign wrReq = wrReq_r;
	assign wrValid = wrValid_r;
	assign evDone = evDone_r;
	assign evDrop = evDrop_r;
endmodule

// ===== verification/mbw_slave_sva.sv
/*
 Port checker for the message handler: handshakes, pulses, drop timing, broadcast silence.
 Assumes it is bound to mbw_slave with every port connected by name.
*/
`timescale 1ns/100ps
module mbw_slave_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [7:0] slaveAddr,
	input wire logic [7:0] rxByte,
	input wire logic rxValid,
	input wire logic rxErr,
	input wire logic rxEnd,
	input wire logic busy,
	input wire logic [7:0] txByte,
	input wire logic txValid,
	input wire logic txReady,
	input wire mbw_pkg::mbw_wr_t wrReq,
	input wire logic wrValid,
	input wire logic wrReady,
	input wire logic evDone,
	input wire logic evDrop
);
	logic inFrame_r, bcast_r;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	// First byte of a frame tells whether it is a broadcast
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			inFrame_r <= 1'b0;
			bcast_r <= 1'b0;
		end
		else
		begin
			if (rxValid && !inFrame_r)
				bcast_r <= (rxByte == 8'h00);
			if (rxValid)
				inFrame_r <= 1'b1;
			else if (rxEnd)
				inFrame_r <= 1'b0;
		end
	end
	chk_tx_hold:
		assert property (txValid && !txReady |=> txValid && $stable(txByte))
		else $error("reply byte changed before taken");
	chk_wr_hold:
		assert property (wrValid && !wrReady |=> wrValid && $stable(wrReq))
		else $error("write word changed before taken");
	chk_wr_next:
		assert property (wrValid && wrReady ##1 wrValid |-> wrReq.addr == $past(wrReq.addr) + 16'h0001)
		else $error("write address not consecutive");
	chk_wr_start:
		assert property ($rose(wrValid) |-> $past(rxEnd, 3))
		else $error("first write at wrong cycle");
	chk_done_pulse:
		assert property (evDone |=> !evDone)
		else $error("done longer than one cycle");
	chk_drop_pulse:
		assert property (evDrop |-> $past(rxEnd, 2) ##1 !evDrop)
		else $error("drop pulse wrong time or width");
	chk_drop_quiet:
		assert property (evDrop |-> !txValid && !wrValid)
		else $error("dropped frame still acted on");
	chk_bcast_silent:
		assert property (bcast_r |-> !txValid)
		else $error("reply sent for broadcast");
	cover property (wrValid && wrReady ##1 wrValid && wrReady);
	cover property (evDrop);
	cover property (txValid && !txReady ##1 txValid && txReady);
endmodule

// ===== verification/mbw_master.sv
/*
 Serial master model: feeds query bytes and frame ends, takes reply bytes, can pace slowly.
 Assumes the bench builds each query, check word included.
*/
`timescale 1ns/100ps
module mbw_master (
	input wire logic clk_sys,
	output logic [7:0] rxByte,
	output logic rxValid,
	output logic rxErr,
	output logic rxEnd,
	input wire logic [7:0] txByte,
	input wire logic txValid,
	output logic txReady
);
	logic slow;
	logic [7:0] reply[$];
	// Idle line, ready transmitter
	initial
	begin
		{rxByte, rxValid, rxErr, rxEnd, slow} = 12'h000;
		txReady = 1'b1;
	end
	// One byte per cycle, a gap, then the frame end; bad marks a line error
	task automatic send(input logic [7:0] f[$], input logic bad);
		foreach (f[i])
		begin
			@(posedge clk_sys);
			#1;
			rxByte = f[i];
			rxValid = 1'b1;
			rxErr = bad && (i == 2);
		end
		@(posedge clk_sys);
		#1;
		rxValid = 1'b0;
		rxErr = 1'b0;
		rxByte = ~rxByte; // Stale byte must not be trusted
		@(posedge clk_sys);
		#1;
		rxEnd = 1'b1;
		@(posedge clk_sys);
		#1;
		rxEnd = 1'b0;
	endtask
	// Collect reply bytes; slow pacing stalls every other cycle
	always @(posedge clk_sys)
	begin
		if (txValid && txReady)
			reply.push_back(txByte);
		txReady <= #1 slow ? ~txReady : 1'b1;
	end
endmodule

// ===== verification/tb_modbus_rtu_write_diag_slave.sv
/*
 Bench for the message handler: writes, loop test, broadcast, drops, exceptions.
 Assumes the package, defines header, master model and checker are compiled first.
*/
`timescale 1ns/100ps
`include "mbw_defines.svh"
module tb_modbus_rtu_write_diag_slave;
	logic clk_sys, rst_b, busy, wrReady, slowWr, rxValid, rxErr, rxEnd, txValid, txReady;
	logic wrValid, evDone, evDrop;
	logic [7:0] rxByte, txByte, q[$];
	mbw_pkg::mbw_wr_t wrReq, wr[$];
	int num_errors, check_count, cycles;
	mbw_slave u_mbw_slave (.clk_sys(clk_sys), .rst_b(rst_b), .slaveAddr(8'h05),
		.rxByte(rxByte), .rxValid(rxValid), .rxErr(rxErr), .rxEnd(rxEnd), .busy(busy),
		.txByte(txByte), .txValid(txValid), .txReady(txReady), .wrReq(wrReq),
		.wrValid(wrValid), .wrReady(wrReady), .evDone(evDone), .evDrop(evDrop));
	mbw_master u_mbw_master (.clk_sys(clk_sys), .rxByte(rxByte), .rxValid(rxValid),
		.rxErr(rxErr), .rxEnd(rxEnd), .txByte(txByte), .txValid(txValid), .txReady(txReady));
	task automatic conclude();
		$display("Errors %0d, checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// Append the check word, low byte first
	task automatic seal(ref logic [7:0] f[$]);
		logic [15:0] c;
		c = `MBW_CRC_INIT;
		foreach (f[i])
		begin
			c ^= {8'h00, f[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ `MBW_CRC_POLY : c >> 1;
		end
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
	endtask
	task automatic run(input logic bad, output logic dropped);
		int n;
		n = 0;
		wr.delete();
		u_mbw_master.reply.delete();
		u_mbw_master.send(q, bad);
		while (evDone !== 1'b1 && evDrop !== 1'b1 && n < 3000)
		begin
			@(negedge clk_sys);
			n++;
		end
		dropped = evDrop;
		check(32'(n < 3000), 32'd1);
		repeat (4) @(posedge clk_sys); // Processing gap before the next query
		#1;
	endtask
	task automatic cmpReply(input logic [7:0] e[$]);
		check(32'(u_mbw_master.reply.size()), 32'(e.size()));
		foreach (e[i])
			check(32'(u_mbw_master.reply[i]), 32'(e[i]));
	endtask
	task automatic tSingle();
		logic d;
		q = '{8'h05, 8'h06, 8'h00, 8'h0d, 8'h17, 8'h70};
		seal(q);
		run(1'b0, d);
		check(wr[0], {16'h000d, 16'h1770});
		cmpReply(q);
	endtask
	// Loop test, never sent as broadcast
	task automatic tDiag();
		logic d;
		u_mbw_master.slow = 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			q = '{8'h05, 8'h08, 8'h00, 8'h00, 8'(k * 255), 8'(k * 255)};
			seal(q);
			run(1'b0, d);
			check(32'(wr.size()), 32'd0);
			cmpReply(q);
		end
		u_mbw_master.slow = 1'b0;
	endtask
	task automatic tMulti(input logic [15:0] start, input int n);
		logic d;
		logic [7:0] e[$];
		q = '{8'h05, 8'h10, start[15:8], start[7:0], 8'h00, 8'(n), 8'(2 * n)};
		for (int i = 0; i < n; i++)
		begin
			q.push_back(8'(i) ^ 8'ha5);
			q.push_back(8'(i));
		end
		e = q[0:5];
		seal(q);
		seal(e);
		slowWr = 1'b1;
		run(1'b0, d);
		slowWr = 1'b0;
		check(32'(wr.size()), 32'(n));
		foreach (wr[i])
			check(wr[i], {start + 16'(i), 8'(i) ^ 8'ha5, 8'(i)});
		cmpReply(e);
	endtask
	task automatic tBcast();
		logic d;
		q = '{8'h00, 8'h06, 8'h0f, 8'hff, 8'hab, 8'hcd};
		seal(q);
		run(1'b0, d);
		check(32'(d), 32'd0);
		check(wr[0], {16'h0fff, 16'habcd});
		check(32'(u_mbw_master.reply.size()), 32'd0);
	endtask
	// Bad check word, line error, busy, frame for another slave
	task automatic tDrop();
		logic d;
		for (int k = 0; k < 4; k++)
		begin
			q = '{(k == 3) ? 8'h06 : 8'h05, 8'h06, 8'h03, 8'he8, 8'h00, 8'h01};
			seal(q);
			q[7] = (k == 0) ? ~q[7] : q[7];
			busy = (k == 2);
			run(k == 1, d);
			check(32'(d), 32'd1);
			check(32'(wr.size() + u_mbw_master.reply.size()), 32'd0);
		end
		busy = 1'b0;
	endtask
	// Unknown function, area just past the end, byte count not twice the count
	task automatic tExc();
		logic d;
		logic [7:0] e[$];
		for (int k = 0; k < 3; k++)
		begin
			q = '{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
			if (k == 1)
				q = '{8'h05, 8'h06, 8'h01, 8'h00, 8'h00, 8'h01};
			if (k == 2)
				q = '{8'h05, 8'h10, 8'h03, 8'he8, 8'h00, 8'h01, 8'h04, 8'h00, 8'h01};
			e = '{8'h05, q[1] | 8'h80, 8'(k + 1)};
			seal(q);
			seal(e);
			run(1'b0, d);
			check(32'(wr.size()), 32'd0);
			cmpReply(e);
		end
	endtask
	// 4 ns clock
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Store side pacing, write capture and hang guard
	always @(posedge clk_sys)
	begin
		if (wrValid && wrReady)
			wr.push_back(wrReq);
		wrReady <= #1 slowWr ? ~wrReady : 1'b1;
		cycles++;
		if (cycles == 20000)
		begin
			$display("Error at %0t: run did not finish", $time);
			num_errors++;
			conclude();
		end
	end
	initial
	begin
		{rst_b, busy, slowWr, num_errors, check_count, cycles} = '0;
		wrReady = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		tSingle();
		tDiag();
		tMulti(16'h03ee, 2);
		tMulti(16'h0000, 125);
		tBcast();
		tDrop();
		tExc();
		conclude();
	end
endmodule
bind mbw_slave mbw_slave_chk u_mbw_slave_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.slaveAddr(slaveAddr), .rxByte(rxByte), .rxValid(rxValid), .rxErr(rxErr), .rxEnd(rxEnd),
	.busy(busy), .txByte(txByte), .txValid(txValid), .txReady(txReady), .wrReq(wrReq),
	.wrValid(wrValid), .wrReady(wrReady), .evDone(evDone), .evDrop(evDrop));
